// ===== core/xcvr_pll_reconfig_ctl.sv
// Reconfiguration controller: shifts settings into the PLL, commits them,
// resets the PLL and sequences the channel resets.
`timescale 1ns/10ps
module xcvr_pll_reconfig_ctl #(
    parameter int CHAIN_LEN = xcvr_pll_reconfig_pkg::CHAIN_LEN
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    xcvr_pll_reconfig_if.ctrl      link,
    input  wire logic              i_user_pll_rst,
    input  wire logic              i_start,
    input  wire logic [CHAIN_LEN-1:0] i_cfg_data,
    input  wire logic              i_m_changed,
    input  wire logic              i_chan_done,
    input  wire logic              i_rx_freqlocked,
    output logic                   o_busy,
    output logic [CHAIN_LEN-1:0]   o_readback,
    output logic                   o_tx_logic_rst,
    output logic                   o_rx_logic_rst,
    output logic                   o_rx_front_rst,
    output logic                   o_chan_req
);

    localparam int HALF     = xcvr_pll_reconfig_pkg::SCAN_DIV / 2;
    localparam int DIV_W    = $clog2(HALF + 1);
    localparam int BIT_W    = $clog2(CHAIN_LEN + 1);
    localparam int RST_W    =
        $clog2(xcvr_pll_reconfig_pkg::PLL_RST_CYCLES + 1);
    localparam int WAIT_W   =
        $clog2(xcvr_pll_reconfig_pkg::FREQLOCK_WAIT_CYC + 1);
    localparam logic [DIV_W-1:0]  DIV_LAST  = DIV_W'(HALF - 1);
    localparam logic [BIT_W-1:0]  BIT_LAST  = BIT_W'(CHAIN_LEN);
    localparam logic [RST_W-1:0]  RST_LAST  =
        RST_W'(xcvr_pll_reconfig_pkg::PLL_RST_CYCLES - 1);
    localparam logic [WAIT_W-1:0] WAIT_LAST =
        WAIT_W'(xcvr_pll_reconfig_pkg::FREQLOCK_WAIT_CYC - 1);

    xcvr_pll_reconfig_pkg::ctl_state_type state_reg;
    logic [DIV_W-1:0]     div_cnt_reg;
    logic                 scanclk_reg;
    logic                 fall_evt;
    logic [1:0]           done_sync_reg;
    logic                 done_prev_reg;
    logic [1:0]           dout_sync_reg;
    logic [1:0]           lock_sync_reg;
    logic                 done_rise;
    logic [BIT_W-1:0]     bit_cnt_reg;
    logic [CHAIN_LEN-1:0] shift_reg;
    logic [CHAIN_LEN-1:0] rb_reg;
    logic [RST_W-1:0]     rst_cnt_reg;
    logic [WAIT_W-1:0]    wait_cnt_reg;
    logic                 m_chg_reg;
    logic                 scandata_reg;
    logic                 scanena_reg;
    logic                 update_reg;
    logic                 areset_reg;

    assign fall_evt  = (div_cnt_reg == DIV_LAST) && scanclk_reg;
    assign done_rise = done_sync_reg[1] && !done_prev_reg;

    assign link.scanclk      = scanclk_reg;
    assign link.scandata     = scandata_reg;
    assign link.scanclkena   = scanena_reg;
    assign link.configupdate = update_reg;
    assign link.areset       = areset_reg;

    // Scan clock divider; link data changes on the falling scan edge.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            div_cnt_reg <= '0;
            scanclk_reg <= 1'b0;
        end else if (i_ce) begin
            if (div_cnt_reg == DIV_LAST) begin
                div_cnt_reg <= '0;
                scanclk_reg <= !scanclk_reg;
            end else begin
                div_cnt_reg <= div_cnt_reg + DIV_W'(1);
            end
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            done_sync_reg <= 2'h0;
            done_prev_reg <= 1'b0;
            dout_sync_reg <= 2'h0;
            lock_sync_reg <= 2'h0;
        end else if (i_ce) begin
            done_sync_reg <= {done_sync_reg[0], link.reconfig_done};
            done_prev_reg <= done_sync_reg[1];
            dout_sync_reg <= {dout_sync_reg[0], link.scandataout};
            lock_sync_reg <= {lock_sync_reg[0], i_rx_freqlocked};
        end
    end

    // PLL reset: user controlled at start-up, then set by the controller
    // at the first edge that sees reprogramming finished.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            areset_reg <= 1'b0;
        end else if (i_ce) begin
            areset_reg <= i_user_pll_rst
                || ((state_reg == xcvr_pll_reconfig_pkg::CTL_UPDATE
                     || state_reg == xcvr_pll_reconfig_pkg::CTL_WAIT_DONE)
                    && done_rise)
                || (state_reg == xcvr_pll_reconfig_pkg::CTL_PLL_RST
                    && rst_cnt_reg != RST_LAST);
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg      <= xcvr_pll_reconfig_pkg::CTL_IDLE;
            o_busy         <= 1'b0;
            o_readback     <= '0;
            o_tx_logic_rst <= 1'b0;
            o_rx_logic_rst <= 1'b0;
            o_rx_front_rst <= 1'b0;
            o_chan_req     <= 1'b0;
            bit_cnt_reg    <= '0;
            shift_reg      <= '0;
            rb_reg         <= '0;
            rst_cnt_reg    <= '0;
            wait_cnt_reg   <= '0;
            m_chg_reg      <= 1'b0;
            scandata_reg   <= 1'b0;
            scanena_reg    <= 1'b0;
            update_reg     <= 1'b0;
        end else if (i_ce) begin
            o_chan_req <= 1'b0;
            case (state_reg)
                xcvr_pll_reconfig_pkg::CTL_IDLE: begin
                    if (i_start) begin
                        o_busy      <= 1'b1;
                        shift_reg   <= i_cfg_data;
                        bit_cnt_reg <= '0;
                        m_chg_reg   <= i_m_changed;
                        if (i_m_changed) begin
                            o_tx_logic_rst <= 1'b1;
                            o_rx_logic_rst <= 1'b1;
                            o_rx_front_rst <= 1'b1;
                        end
                        state_reg <= xcvr_pll_reconfig_pkg::CTL_SHIFT;
                    end
                end
                xcvr_pll_reconfig_pkg::CTL_SHIFT: begin
                    if (fall_evt) begin
                        if (bit_cnt_reg == BIT_LAST) begin
                            scanena_reg <= 1'b0;
                            update_reg  <= 1'b1;
                            state_reg   <= xcvr_pll_reconfig_pkg::CTL_UPDATE;
                        end else begin
                            rb_reg       <= {rb_reg[CHAIN_LEN-2:0],
                                             dout_sync_reg[1]};
                            scandata_reg <= shift_reg[CHAIN_LEN-1];
                            shift_reg    <= {shift_reg[CHAIN_LEN-2:0], 1'b0};
                            scanena_reg  <= 1'b1;
                            bit_cnt_reg  <= bit_cnt_reg + BIT_W'(1);
                        end
                    end
                end
                xcvr_pll_reconfig_pkg::CTL_UPDATE: begin
                    // Scan complete returns before the next scan fall, so
                    // its synchronised edge must be caught here as well.
                    if (done_rise) begin
                        update_reg  <= 1'b0;
                        rst_cnt_reg <= '0;
                        state_reg   <= xcvr_pll_reconfig_pkg::CTL_PLL_RST;
                    end else if (fall_evt) begin
                        update_reg <= 1'b0;
                        state_reg  <= xcvr_pll_reconfig_pkg::CTL_WAIT_DONE;
                    end
                end
                xcvr_pll_reconfig_pkg::CTL_WAIT_DONE: begin
                    if (done_rise) begin
                        rst_cnt_reg <= '0;
                        state_reg   <= xcvr_pll_reconfig_pkg::CTL_PLL_RST;
                    end
                end
                xcvr_pll_reconfig_pkg::CTL_PLL_RST: begin
                    rst_cnt_reg <= rst_cnt_reg + RST_W'(1);
                    if (rst_cnt_reg == RST_LAST) begin
                        o_readback <= rb_reg;
                        if (m_chg_reg) begin
                            o_chan_req <= 1'b1;
                            state_reg  <= xcvr_pll_reconfig_pkg::CTL_CHAN;
                        end else begin
                            o_busy    <= 1'b0;
                            state_reg <= xcvr_pll_reconfig_pkg::CTL_IDLE;
                        end
                    end
                end
                xcvr_pll_reconfig_pkg::CTL_CHAN: begin
                    if (i_chan_done) begin
                        o_tx_logic_rst <= 1'b0;
                        o_rx_front_rst <= 1'b0;
                        state_reg <= xcvr_pll_reconfig_pkg::CTL_WAIT_LOCK;
                    end
                end
                xcvr_pll_reconfig_pkg::CTL_WAIT_LOCK: begin
                    if (lock_sync_reg[1]) begin
                        wait_cnt_reg <= '0;
                        state_reg    <= xcvr_pll_reconfig_pkg::CTL_WAIT_US;
                    end
                end
                xcvr_pll_reconfig_pkg::CTL_WAIT_US: begin
                    wait_cnt_reg <= wait_cnt_reg + WAIT_W'(1);
                    if (wait_cnt_reg == WAIT_LAST) begin
                        o_rx_logic_rst <= 1'b0;
                        o_busy         <= 1'b0;
                        state_reg      <= xcvr_pll_reconfig_pkg::CTL_IDLE;
                    end
                end
                default: begin
                    state_reg <= xcvr_pll_reconfig_pkg::CTL_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== core/xcvr_pll_reconfig_pkg.sv
// Shared constants and state types for the transceiver PLL reconfiguration.
package xcvr_pll_reconfig_pkg;

    localparam int CHAIN_LEN         = 16;
    localparam int AN_W              = 8;
    localparam logic [2:0] MODE_CHAN = 3'h1;
    localparam int CHECK_CYCLES      = 1;
    localparam int ERR_CYCLES        = 2;
    localparam int OP_TIMEOUT        = 64;
    localparam int SCAN_DIV          = 8;
    localparam int LOCK_CYCLES       = 32;
    localparam int PLL_RST_CYCLES    = 4 * SCAN_DIV;
    localparam int CLK_PERIOD_NS     = 25;
    localparam int FREQLOCK_WAIT_NS  = 4000;
    localparam int FREQLOCK_WAIT_CYC =
        (FREQLOCK_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    typedef enum logic [3:0] {
        DEV_IDLE  = 4'b0001,
        DEV_CHECK = 4'b0010,
        DEV_RUN   = 4'b0100,
        DEV_ERR   = 4'b1000
    } dev_state_type;

    typedef enum logic [7:0] {
        CTL_IDLE      = 8'b0000_0001,
        CTL_SHIFT     = 8'b0000_0010,
        CTL_UPDATE    = 8'b0000_0100,
        CTL_WAIT_DONE = 8'b0000_1000,
        CTL_PLL_RST   = 8'b0001_0000,
        CTL_CHAN      = 8'b0010_0000,
        CTL_WAIT_LOCK = 8'b0100_0000,
        CTL_WAIT_US   = 8'b1000_0000
    } ctl_state_type;

endpackage

// ===== core/xcvr_pll_reconfig_if.sv
// Serial scan link between the reconfiguration controller and the PLL.
`timescale 1ns/10ps
interface xcvr_pll_reconfig_if;
    logic scanclk;
    logic scandata;
    logic scanclkena;
    logic configupdate;
    logic areset;
    logic reconfig_done;
    logic scandataout;

    modport device (
        input  scanclk,
        input  scandata,
        input  scanclkena,
        input  configupdate,
        input  areset,
        output reconfig_done,
        output scandataout
    );

    modport ctrl (
        output scanclk,
        output scandata,
        output scanclkena,
        output configupdate,
        output areset,
        input  reconfig_done,
        input  scandataout
    );
endinterface

// ===== core/xcvr_pll_reconfig_dev.sv
// Reconfigurable transceiver PLL scan chain and dynamic reconfiguration
// controller with illegal-request and self-recovery error reporting.
// Operation
// - User logic drives PLL reset during initial sequence.
// - Controller resets PLL one edge after done.
// - PLL takes reconfigurable bits from serial input.
// - Chain shifts only on gated scan clock edges.
// - Commit asserted only after last data bit.
// - Reprogram-finished raised from PLL scan complete.
// - Current configuration shifted out for readback.
// - Hold resets, reprogram PLL and channels, release.
// - Wait 4 us after lock before logic release.
// - Illegal request: drop busy, error two cycles.
// - Read illegal without analog readback outputs.
// - Write-all illegal without analog control inputs.
// - Read illegal in channel reconfiguration mode.
// - Overrun abandoned: drop busy, error two cycles.
// - Out-of-range analog value raises no error.
// - Error output exists only when checks enabled; the code also drives it when only SELF_RECOVERY is set.
`timescale 1ns/10ps
module xcvr_pll_reconfig_dev #(
    parameter int CHAIN_LEN     = xcvr_pll_reconfig_pkg::CHAIN_LEN,
    parameter int AN_W          = xcvr_pll_reconfig_pkg::AN_W,
    parameter bit CHECK_ILLEGAL = 1'b1,
    parameter bit SELF_RECOVERY = 1'b1,
    parameter bit HAS_AN_OUT    = 1'b1,
    parameter bit HAS_AN_IN     = 1'b1
) (
    input  wire logic              i_mclk,
    input  wire logic              i_rst,
    input  wire logic              i_ce,
    xcvr_pll_reconfig_if.device    link,
    input  wire logic              i_read,
    input  wire logic              i_write_all,
    input  wire logic [2:0]        i_mode_sel,
    input  wire logic [AN_W-1:0]   i_an_wdata,
    input  wire logic              i_pma_ready,
    output logic                   o_busy,
    output logic                   o_error,
    output logic [AN_W-1:0]        o_an_rdata,
    output logic [CHAIN_LEN-1:0]   o_pll_cfg,
    output logic                   o_pll_locked
);

    localparam int LOCK_W = $clog2(xcvr_pll_reconfig_pkg::LOCK_CYCLES + 1);
    localparam int TMO_W  = $clog2(xcvr_pll_reconfig_pkg::OP_TIMEOUT + 1);
    localparam logic [LOCK_W-1:0] LOCK_LAST =
        LOCK_W'(xcvr_pll_reconfig_pkg::LOCK_CYCLES - 1);
    localparam logic [TMO_W-1:0] TMO_LAST =
        TMO_W'(xcvr_pll_reconfig_pkg::OP_TIMEOUT - 1);
    localparam logic [1:0] ERR_LAST =
        2'(xcvr_pll_reconfig_pkg::ERR_CYCLES - 1);
    localparam bit ERR_PRESENT = CHECK_ILLEGAL | SELF_RECOVERY;

    // Link-domain state, clocked by the scan clock.
    logic [1:0]           ce_sync_reg;
    logic [1:0]           arst_sync_reg;
    logic [CHAIN_LEN-1:0] chain_reg;
    logic                 done_reg;
    logic [LOCK_W-1:0]    lock_cnt_reg;
    logic                 ce_link;
    logic                 arst_link;

    // Controller state, clocked by the reconfiguration clock.
    xcvr_pll_reconfig_pkg::dev_state_type state_reg;
    logic                 op_read_reg;
    logic [2:0]           op_mode_reg;
    logic [AN_W-1:0]      op_wdata_reg;
    logic [AN_W-1:0]      an_setting_reg;
    logic [TMO_W-1:0]     tmo_cnt_reg;
    logic [1:0]           err_cnt_reg;
    logic                 illegal;

    assign ce_link   = ce_sync_reg[1];
    assign arst_link = arst_sync_reg[1];

    // Clock enable and PLL reset enter the scan clock domain through
    // two flip-flops each.
    always_ff @(posedge link.scanclk or posedge i_rst) begin
        if (i_rst) begin
            ce_sync_reg   <= 2'h0;
            arst_sync_reg <= 2'h0;
        end else begin
            ce_sync_reg   <= {ce_sync_reg[0], i_ce};
            arst_sync_reg <= {arst_sync_reg[0], link.areset};
        end
    end

    always_ff @(posedge link.scanclk or posedge i_rst) begin
        if (i_rst) begin
            chain_reg <= '0;
        end else if (ce_link && link.scanclkena) begin
            chain_reg <= {chain_reg[CHAIN_LEN-2:0], link.scandata};
        end
    end

    // The old configuration leaves the chain msb first as new bits enter.
    assign link.scandataout = chain_reg[CHAIN_LEN-1];

    // Commit copies the chain into the active configuration and raises
    // scan complete, which stands until the PLL reset arrives.
    always_ff @(posedge link.scanclk or posedge i_rst) begin
        if (i_rst) begin
            o_pll_cfg <= '0;
            done_reg  <= 1'b0;
        end else if (ce_link) begin
            if (link.configupdate && !done_reg) begin
                o_pll_cfg <= chain_reg;
                done_reg  <= 1'b1;
            end else if (arst_link) begin
                done_reg <= 1'b0;
            end
        end
    end

    assign link.reconfig_done = done_reg;

    // Lock is lost on every PLL reset and regained after a fixed count.
    always_ff @(posedge link.scanclk or posedge i_rst) begin
        if (i_rst) begin
            lock_cnt_reg <= '0;
            o_pll_locked <= 1'b0;
        end else if (ce_link) begin
            if (arst_link) begin
                lock_cnt_reg <= '0;
                o_pll_locked <= 1'b0;
            end else if (!o_pll_locked) begin
                lock_cnt_reg <= lock_cnt_reg + LOCK_W'(1);
                o_pll_locked <= (lock_cnt_reg == LOCK_LAST);
            end
        end
    end

    // Request legality, decided on the latched request.
    always_comb begin
        illegal = 1'b0;
        if (op_read_reg && !HAS_AN_OUT) begin
            illegal = 1'b1;
        end
        if (!op_read_reg && !HAS_AN_IN) begin
            illegal = 1'b1;
        end
        if (op_read_reg && op_mode_reg == xcvr_pll_reconfig_pkg::MODE_CHAN)
        begin
            illegal = 1'b1;
        end
    end

    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            state_reg    <= xcvr_pll_reconfig_pkg::DEV_IDLE;
            o_busy       <= 1'b0;
            o_error      <= 1'b0;
            op_read_reg  <= 1'b0;
            op_mode_reg  <= 3'h0;
            op_wdata_reg <= '0;
            tmo_cnt_reg  <= '0;
            err_cnt_reg  <= 2'h0;
        end else if (i_ce) begin
            case (state_reg)
                xcvr_pll_reconfig_pkg::DEV_IDLE: begin
                    if (i_read || i_write_all) begin
                        o_busy       <= 1'b1;
                        op_read_reg  <= i_read;
                        op_mode_reg  <= i_mode_sel;
                        op_wdata_reg <= i_an_wdata;
                        tmo_cnt_reg  <= '0;
                        state_reg    <= xcvr_pll_reconfig_pkg::DEV_CHECK;
                    end
                end
                xcvr_pll_reconfig_pkg::DEV_CHECK: begin
                    if (CHECK_ILLEGAL && illegal) begin
                        o_busy      <= 1'b0;
                        o_error     <= ERR_PRESENT;
                        err_cnt_reg <= 2'h0;
                        state_reg   <= xcvr_pll_reconfig_pkg::DEV_ERR;
                    end else begin
                        state_reg <= xcvr_pll_reconfig_pkg::DEV_RUN;
                    end
                end
                xcvr_pll_reconfig_pkg::DEV_RUN: begin
                    tmo_cnt_reg <= tmo_cnt_reg + TMO_W'(1);
                    if (i_pma_ready) begin
                        o_busy    <= 1'b0;
                        state_reg <= xcvr_pll_reconfig_pkg::DEV_IDLE;
                    end else if (SELF_RECOVERY && tmo_cnt_reg == TMO_LAST)
                    begin
                        o_busy      <= 1'b0;
                        o_error     <= ERR_PRESENT;
                        err_cnt_reg <= 2'h0;
                        state_reg   <= xcvr_pll_reconfig_pkg::DEV_ERR;
                    end
                end
                xcvr_pll_reconfig_pkg::DEV_ERR: begin
                    err_cnt_reg <= err_cnt_reg + 2'h1;
                    if (err_cnt_reg == ERR_LAST) begin
                        o_error   <= 1'b0;
                        state_reg <= xcvr_pll_reconfig_pkg::DEV_IDLE;
                    end
                end
                default: begin
                    o_busy    <= 1'b0;
                    o_error   <= 1'b0;
                    state_reg <= xcvr_pll_reconfig_pkg::DEV_IDLE;
                end
            endcase
        end
    end

    // Analog settings store any value written; range is not judged.
    always_ff @(posedge i_mclk or posedge i_rst) begin
        if (i_rst) begin
            an_setting_reg <= '0;
            o_an_rdata     <= '0;
        end else if (i_ce && state_reg == xcvr_pll_reconfig_pkg::DEV_RUN
                     && i_pma_ready) begin
            if (op_read_reg) begin
                o_an_rdata <= an_setting_reg;
            end else begin
                an_setting_reg <= op_wdata_reg;
            end
        end
    end

endmodule

// ===== bench/xcvr_pll_reconfig_checker.sv
// Assertions on the scan link between the controller and the PLL.
`timescale 1ns/10ps
module xcvr_pll_reconfig_checker (
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic scanclk,
    input wire logic scanclkena,
    input wire logic configupdate,
    input wire logic areset,
    input wire logic reconfig_done,
    input wire logic scandataout
);
    property p_rst_after_done;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(reconfig_done) |-> ##[1:4] areset;
    endproperty
    a_rst_after_done: assert property (p_rst_after_done)
        else $error("pll reset missing after reprogram");
    property p_rst_hold;
        @(posedge i_mclk) disable iff (i_rst)
        $rose(areset) |-> areset [*8];
    endproperty
    a_rst_hold: assert property (p_rst_hold)
        else $error("pll reset too short");
    property p_commit_after_last;
        @(posedge scanclk) disable iff (i_rst)
        $rose(configupdate) |-> !scanclkena && $past(scanclkena);
    endproperty
    a_commit_after_last: assert property (p_commit_after_last)
        else $error("commit not right after last bit");
    property p_no_commit_in_shift;
        @(posedge scanclk) disable iff (i_rst)
        scanclkena |-> !configupdate;
    endproperty
    a_no_commit_in_shift: assert property (p_no_commit_in_shift)
        else $error("commit during shift");
    property p_commit_one;
        @(posedge scanclk) disable iff (i_rst)
        $rose(configupdate) |=> !configupdate;
    endproperty
    a_commit_one: assert property (p_commit_one)
        else $error("commit longer than one period");
    property p_done_follows;
        @(posedge scanclk) disable iff (i_rst)
        $rose(configupdate) |-> ##[0:2] reconfig_done;
    endproperty
    a_done_follows: assert property (p_done_follows)
        else $error("finish flag missing after commit");
    property p_done_cause;
        @(posedge scanclk) disable iff (i_rst)
        $rose(reconfig_done) |-> $past(configupdate);
    endproperty
    a_done_cause: assert property (p_done_cause)
        else $error("finish flag without commit");
    property p_out_gated;
        @(posedge scanclk) disable iff (i_rst)
        !$past(scanclkena) |-> $stable(scandataout);
    endproperty
    a_out_gated: assert property (p_out_gated)
        else $error("chain moved without enable");
endmodule

// ===== bench/xcvr_pll_reconfig_control_tb_top.sv
// Bench joining the controller and the PLL over the scan link.
`timescale 1ns/10ps
module xcvr_pll_reconfig_control_tb_top;
    logic        i_mclk, i_rst, ce, rd, wr, rdy, start, urst, mchg;
    logic        cdone, flock, d_busy, d_err, c_busy, txr, rxl, rxf, creq, lck;
    logic [2:0]  mode;
    logic [7:0]  wdat, rdat;
    logic [15:0] cfg, pcfg, rb;
    int          err_count, num_checks, n;
    xcvr_pll_reconfig_if lk ();
    xcvr_pll_reconfig_dev xcvr_pll_reconfig_dev_inst (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_ce(ce), .link(lk), .i_read(rd),
        .i_write_all(wr), .i_mode_sel(mode), .i_an_wdata(wdat),
        .i_pma_ready(rdy), .o_busy(d_busy), .o_error(d_err),
        .o_an_rdata(rdat), .o_pll_cfg(pcfg), .o_pll_locked(lck));
    xcvr_pll_reconfig_ctl xcvr_pll_reconfig_ctl_inst (.i_mclk(i_mclk),
        .i_rst(i_rst), .i_ce(ce), .link(lk), .i_user_pll_rst(urst),
        .i_start(start), .i_cfg_data(cfg), .i_m_changed(mchg),
        .i_chan_done(cdone), .i_rx_freqlocked(flock), .o_busy(c_busy),
        .o_readback(rb), .o_tx_logic_rst(txr), .o_rx_logic_rst(rxl),
        .o_rx_front_rst(rxf), .o_chan_req(creq));
    xcvr_pll_reconfig_checker xcvr_pll_reconfig_checker_inst (
        .i_mclk(i_mclk), .i_rst(i_rst), .scanclk(lk.scanclk),
        .scanclkena(lk.scanclkena), .configupdate(lk.configupdate),
        .areset(lk.areset), .reconfig_done(lk.reconfig_done),
        .scandataout(lk.scandataout));
    task automatic chk(input string s, input logic [15:0] e, g);
        num_checks++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", s, e, g);
            err_count++;
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic step;
        @(posedge i_mclk);
        #1;
    endtask
    // Returns in n how many cycles busy stood after the request.
    task automatic dev_op(input logic r, w, input logic [2:0] m);
        @(posedge i_mclk);
        rd <= r;
        wr <= w;
        mode <= m;
        n = 0;
        while (n < 8 && d_busy !== 1'b1) begin
            step();
            n++;
        end
        @(posedge i_mclk);
        rd <= 1'b0;
        wr <= 1'b0;
        #1;
        n = 1;
        while (n < 200 && d_busy === 1'b1) begin
            step();
            n++;
        end
    endtask
    task automatic ctl_run(input logic [15:0] c, input logic m);
        @(posedge i_mclk);
        cfg <= c;
        mchg <= m;
        start <= 1'b1;
        @(posedge i_mclk);
        start <= 1'b0;
        #1;
        chk("ctl busy", 1, c_busy);
        chk("resets held", {3{m}}, {txr, rxl, rxf});
        n = 0;
        while (n < 4000 && creq !== 1'b1 && c_busy === 1'b1) begin
            step();
            n++;
        end
        chk("pll cfg", c, pcfg);
        if (m) begin
            @(posedge i_mclk);
            cdone <= 1'b1;
            repeat (4) step();
            chk("resets", 3'b010, {txr, rxl, rxf});
            @(posedge i_mclk);
            flock <= 1'b1;
        end
        n = 0;
        while (n < 4000 && c_busy === 1'b1) begin
            step();
            n++;
        end
        chk("lock wait", 1, m ? n >= 160 : 1);
        chk("rx rst", 0, rxl);
        chk("pll cfg", c, pcfg);
        @(posedge i_mclk);
        cdone <= 1'b0;
        flock <= 1'b0;
    endtask
    initial begin
        i_mclk = 1'b0;
        forever #12.5 i_mclk = ~i_mclk;
    end
    initial begin
        repeat (20000) @(posedge i_mclk);
        err_count++;
        tally_and_finish();
    end
    initial begin
        {i_rst, ce} = 2'b11;
        {rd, wr, rdy, start, urst, mchg, cdone, flock} = 8'h00;
        mode = 3'h0;
        wdat = 8'hff;
        cfg = 16'h0000;
        repeat (6) @(posedge i_mclk);
        i_rst <= 1'b0;
        urst <= 1'b1;
        repeat (3) step();
        chk("pll reset", 1, lk.areset);
        repeat (8) @(posedge i_mclk);
        urst <= 1'b0;
        ctl_run(16'ha5c3, 1'b0);
        ctl_run(16'h3c5a, 1'b1);
        chk("readback", 16'ha5c3, rb);
        chk("pll unlocked", 0, lck);
        rdy <= 1'b1;
        dev_op(1'b0, 1'b1, 3'h0);
        chk("write err", 0, d_err);
        dev_op(1'b1, 1'b0, 3'h0);
        chk("read data", 8'hff, rdat);
        dev_op(1'b1, 1'b0, 3'h1);
        chk("illegal busy", 1, n);
        chk("illegal err", 1, d_err);
        step();
        chk("err second", 1, d_err);
        step();
        chk("err third", 0, d_err);
        @(posedge i_mclk);
        rdy <= 1'b0;
        dev_op(1'b0, 1'b1, 3'h0);
        chk("overrun", 1, n >= 64);
        chk("overrun err", 1, d_err);
        n = 0;
        while (n < 400 && lck !== 1'b1) begin
            step();
            n++;
        end
        chk("pll relock", 1, lck);
        tally_and_finish();
    end
endmodule
